// >>> hdl/rx_telecom_bus_clock_out.sv
`timescale 1ns/1ps
`default_nettype none

// How it works
// [RQ1] Enabled channel drives its own bus clock pin.
// [RQ2] All bus outputs launch on clock rise.
// [RQ3] STS-3 mode gives 19.44 MHz bus clock.
// [RQ4] STS-1 mode gives 6.48 MHz bus clock.
// [RQ5] Disabled pin may carry HDLC good-check flag.
// [RQ6] Disabled pin may carry cell flow clock.
// [RQ7] Channel 1 pin may flag packet space.
// [RQ8] Payload flag low only for overhead bytes; the code also holds it low on a disabled channel.
module rx_telecom_bus_clock_out #(
  parameter int unsigned FIFO_DEPTH = rx_tbus_pkg::FIFO_DEPTH,
  parameter bit          PARITY_ODD = 1'b1
) (
  // System clock and reset
  input  wire logic                 clk,
  input  wire logic                 reset_n,
  // Link reference clock
  input  wire logic                 link_clk,
  // Configuration, system clock domain
  input  wire logic [2:0]           bus_enable,
  input  wire logic                 sts3_mode,
  input  wire logic [2:0][1:0]      alt_select,
  // Byte streams in, system clock domain
  input  wire logic [2:0]           src_valid,
  output logic [2:0]                src_ready,
  input  wire logic [2:0][7:0]      src_byte,
  input  wire logic [2:0]           src_alarm,
  input  wire logic [2:0]           src_overhead,
  input  wire logic [2:0]           src_frame_marker,
  // Alternate pin functions, system clock domain
  input  wire logic [2:0]           rx_hdlc_good_check,
  input  wire logic [2:0]           rx_cell_flow_clock,
  input  wire logic                 tx_pkt_selected_space_avail,
  // Receive telecom bus pins
  output logic                      rx_bus_clock_out_ch0,
  output logic                      rx_bus_clock_out_ch1,
  output logic                      rx_bus_clock_out_ch2,
  output logic [2:0][7:0]           rx_bus_byte,
  output logic [2:0]                rx_bus_alarm,
  output logic [2:0]                rx_bus_parity,
  output logic [2:0]                rx_bus_payload_flag,
  output logic [2:0]                rx_bus_frame_marker
);

  localparam int unsigned W = rx_tbus_pkg::WORD_W;

  // ==========================================================================
  // Link domain state
  // ==========================================================================
  // Configuration crosses bit by bit; it is quasi-static, so a multi-bit
  // field may show one mixed value for a single link cycle while it changes.
  typedef struct packed {
    logic [1:0]      rst_sync;
    logic [2:0]      en_s1;
    logic [2:0]      en_s2;
    logic            sts3_s1;
    logic            sts3_s2;
    logic [2:0][1:0] alt_s1;
    logic [2:0][1:0] alt_s2;
    logic [2:0]      hdlc_s1;
    logic [2:0]      hdlc_s2;
    logic [2:0]      gfc_s1;
    logic [2:0]      gfc_s2;
    logic            pkt_s1;
    logic            pkt_s2;
    logic [2:0]      pin;
    logic [2:0][7:0] data;
    logic [2:0]      alarm;
    logic [2:0]      parity;
    logic [2:0]      payload;
    logic [2:0]      marker;
  } link_state_t;

  link_state_t                    s_r;
  link_state_t                    s_nxt;
  logic                           link_rst_n;
  logic [2:0]                     f_valid;
  logic [2:0][W-1:0]              f_data;
  logic [2:0]                     pop;
  logic [2:0]                     lvl;
  logic [2:0]                     lvl_nxt;
  logic [2:0]                     rise;
  logic [rx_tbus_pkg::DIV_CNT_W-1:0] div_sel;

  assign link_rst_n = s_r.rst_sync[1];
  assign div_sel    = s_r.sts3_s2 ? rx_tbus_pkg::DIV_STS3_C : rx_tbus_pkg::DIV_STS1_C; // see [RQ3] see [RQ4]

  function automatic logic alt_pin(input logic [1:0] sel,
                                   input logic       hdlc,
                                   input logic       gfc,
                                   input logic       pkt,
                                   input logic       pkt_ok);
    case (sel)
      rx_tbus_pkg::ALT_HDLC_GOOD: return hdlc;
      rx_tbus_pkg::ALT_CELL_FLOW: return gfc;
      rx_tbus_pkg::ALT_PKT_SPACE: return pkt & pkt_ok;
      default:                    return 1'b0;
    endcase
  endfunction : alt_pin

  // ==========================================================================
  // Per-channel buffer and bus clock divider
  // ==========================================================================
  // The buffer is the only path for byte data from the system clock to the bus; when it
  // runs dry the bus sends idle bytes with the alarm raised rather than stall.
  for (genvar g = 0; g < 3; g++) begin : g_ch
    tbus_async_fifo #(
      .WIDTH (W),
      .DEPTH (FIFO_DEPTH)
    ) u_fifo (
      .wclk    (clk),
      .wrst_n  (reset_n),
      .w_valid (src_valid[g]),
      .w_data  ({src_frame_marker[g], src_overhead[g], src_alarm[g], src_byte[g]}),
      .w_ready (src_ready[g]),
      .rclk    (link_clk),
      .rrst_n  (link_rst_n),
      .r_valid (f_valid[g]),
      .r_ready (pop[g]),
      .r_data  (f_data[g])
    );

    tbus_clock_divider #(
      .CNT_W (rx_tbus_pkg::DIV_CNT_W)
    ) u_div (
      .clk       (link_clk),
      .rst_n     (link_rst_n),
      .run       (s_r.en_s2[g]),
      .div       (div_sel),
      .level     (lvl[g]),
      .level_nxt (lvl_nxt[g]),
      .rise      (rise[g])
    );
  end

  // ==========================================================================
  // Link domain next state
  // ==========================================================================
  always_comb begin
    logic [1:0] keep_sync;
    keep_sync        = {s_r.rst_sync[0], reset_n};
    s_nxt            = s_r;
    s_nxt.rst_sync   = keep_sync;
    s_nxt.en_s1      = bus_enable;
    s_nxt.en_s2      = s_r.en_s1;
    s_nxt.sts3_s1    = sts3_mode;
    s_nxt.sts3_s2    = s_r.sts3_s1;
    s_nxt.alt_s1     = alt_select;
    s_nxt.alt_s2     = s_r.alt_s1;
    s_nxt.hdlc_s1    = rx_hdlc_good_check;
    s_nxt.hdlc_s2    = s_r.hdlc_s1;
    s_nxt.gfc_s1     = rx_cell_flow_clock;
    s_nxt.gfc_s2     = s_r.gfc_s1;
    s_nxt.pkt_s1     = tx_pkt_selected_space_avail;
    s_nxt.pkt_s2     = s_r.pkt_s1;
    pop              = '0;
    for (int ch = 0; ch < 3; ch++) begin
      if (s_r.en_s2[ch]) begin
        s_nxt.pin[ch] = lvl_nxt[ch]; // see [RQ1]
        // Data moves only at the edge where the bus clock goes high.
        if (rise[ch]) begin // see [RQ2]
          if (f_valid[ch]) begin
            pop[ch]           = 1'b1;
            s_nxt.data[ch]    = f_data[ch][rx_tbus_pkg::BYTE_LSB +: rx_tbus_pkg::BYTE_W];
            s_nxt.alarm[ch]   = f_data[ch][rx_tbus_pkg::ALARM_BIT];
            s_nxt.payload[ch] = ~f_data[ch][rx_tbus_pkg::OVH_BIT]; // see [RQ8]
            s_nxt.marker[ch]  = f_data[ch][rx_tbus_pkg::MARKER_BIT];
          end else begin
            s_nxt.data[ch]    = rx_tbus_pkg::IDLE_BYTE;
            s_nxt.alarm[ch]   = rx_tbus_pkg::IDLE_ALARM;
            s_nxt.payload[ch] = rx_tbus_pkg::IDLE_PAYLOAD; // see [RQ8]
            s_nxt.marker[ch]  = 1'b0;
          end
          s_nxt.parity[ch] = PARITY_ODD ? ~^s_nxt.data[ch] : ^s_nxt.data[ch];
        end
      end else begin
        s_nxt.pin[ch]     = alt_pin(s_r.alt_s2[ch], s_r.hdlc_s2[ch], s_r.gfc_s2[ch], s_r.pkt_s2,
                                    (ch == rx_tbus_pkg::PKT_CHANNEL)); // see [RQ5] see [RQ6] see [RQ7]
        s_nxt.data[ch]    = '0;
        s_nxt.alarm[ch]   = 1'b0;
        s_nxt.parity[ch]  = 1'b0;
        s_nxt.payload[ch] = 1'b0;
        s_nxt.marker[ch]  = 1'b0;
      end
    end
    if (!link_rst_n) begin
      s_nxt          = '0;
      s_nxt.rst_sync = keep_sync;
      pop            = '0;
    end
  end

  always_ff @(posedge link_clk) begin
    s_r <= s_nxt;
  end

  // ==========================================================================
  // Pins
  // ==========================================================================
  assign rx_bus_clock_out_ch0 = s_r.pin[0];
  assign rx_bus_clock_out_ch1 = s_r.pin[1];
  assign rx_bus_clock_out_ch2 = s_r.pin[2];
  assign rx_bus_byte          = s_r.data;
  assign rx_bus_alarm         = s_r.alarm;
  assign rx_bus_parity        = s_r.parity;
  assign rx_bus_payload_flag  = s_r.payload;
  assign rx_bus_frame_marker  = s_r.marker;

  // ==========================================================================
  // Checks
  // ==========================================================================
  // Period helper for channel 0: counts link cycles between bus clock rises
  // and forgets the first rise after any change of enable or rate.
  logic       pin0_q;
  logic [5:0] gap_r;
  logic       seen_r;
  logic [1:0] cfg_q;
  logic       rise_pin0;
  logic       cfg_same;

  assign rise_pin0 = s_r.pin[0] & ~pin0_q;
  // A rise in the cycle that the rate changes still belongs to the old rate.
  assign cfg_same  = (cfg_q == {s_r.en_s2[0], s_r.sts3_s2});

  always_ff @(posedge link_clk) begin
    pin0_q <= s_r.pin[0];
    cfg_q  <= {s_r.en_s2[0], s_r.sts3_s2};
    if (!link_rst_n || (cfg_q != {s_r.en_s2[0], s_r.sts3_s2})) begin
      gap_r  <= 6'h00;
      seen_r <= 1'b0;
    end else if (rise_pin0) begin
      gap_r  <= 6'h00;
      seen_r <= 1'b1;
    end else begin
      gap_r  <= gap_r + 6'h01;
    end
  end

  property p_pin_is_clock;
    @(posedge link_clk) disable iff (!link_rst_n)
    (s_r.en_s2[0] && $past(s_r.en_s2[0])) |-> (rx_bus_clock_out_ch0 == lvl[0]);
  endproperty
  a_pin_is_clock: assert property (p_pin_is_clock) else $error("Enabled pin does not carry bus clock."); // see [RQ1]

  property p_launch_on_rise;
    @(posedge link_clk) disable iff (!link_rst_n)
    (s_r.en_s2[0] && $past(s_r.en_s2[0]) &&
     $changed({rx_bus_byte[0], rx_bus_alarm[0], rx_bus_payload_flag[0], rx_bus_frame_marker[0]}))
    |-> $rose(rx_bus_clock_out_ch0);
  endproperty
  a_launch_on_rise: assert property (p_launch_on_rise) else $error("Bus output changed off a clock rise."); // see [RQ2]

  property p_sts3_period;
    @(posedge link_clk) disable iff (!link_rst_n)
    (rise_pin0 && seen_r && cfg_same && s_r.en_s2[0] && s_r.sts3_s2) |-> (gap_r == 6'(rx_tbus_pkg::DIV_STS3 - 1));
  endproperty
  a_sts3_period: assert property (p_sts3_period) else $error("Bus clock period wrong in STS-3 mode."); // see [RQ3]

  property p_sts1_period;
    @(posedge link_clk) disable iff (!link_rst_n)
    (rise_pin0 && seen_r && cfg_same && s_r.en_s2[0] && !s_r.sts3_s2) |-> (gap_r == 6'(rx_tbus_pkg::DIV_STS1 - 1));
  endproperty
  a_sts1_period: assert property (p_sts1_period) else $error("Bus clock period wrong in STS-1 mode."); // see [RQ4]

  property p_alt_hdlc;
    @(posedge link_clk) disable iff (!link_rst_n)
    (!s_r.en_s2[0] && s_r.alt_s2[0] == rx_tbus_pkg::ALT_HDLC_GOOD) |=> (rx_bus_clock_out_ch0 == $past(s_r.hdlc_s2[0]));
  endproperty
  a_alt_hdlc: assert property (p_alt_hdlc) else $error("Pin does not carry HDLC good-check flag."); // see [RQ5]

  property p_alt_flow;
    @(posedge link_clk) disable iff (!link_rst_n)
    (!s_r.en_s2[2] && s_r.alt_s2[2] == rx_tbus_pkg::ALT_CELL_FLOW) |=> (rx_bus_clock_out_ch2 == $past(s_r.gfc_s2[2]));
  endproperty
  a_alt_flow: assert property (p_alt_flow) else $error("Pin does not carry cell flow clock."); // see [RQ6]

  property p_alt_pkt;
    @(posedge link_clk) disable iff (!link_rst_n)
    (!s_r.en_s2[1] && s_r.alt_s2[1] == rx_tbus_pkg::ALT_PKT_SPACE) |=> (rx_bus_clock_out_ch1 == $past(s_r.pkt_s2));
  endproperty
  a_alt_pkt: assert property (p_alt_pkt) else $error("Channel 1 pin does not flag packet space."); // see [RQ7]

  property p_payload_flag;
    @(posedge link_clk) disable iff (!link_rst_n)
    pop[0] |=> (rx_bus_payload_flag[0] == ~$past(f_data[0][rx_tbus_pkg::OVH_BIT]));
  endproperty
  a_payload_flag: assert property (p_payload_flag) else $error("Payload flag disagrees with overhead mark."); // see [RQ8]

  property p_cov_sts3;
    @(posedge link_clk) disable iff (!link_rst_n)
    rise_pin0 && seen_r && s_r.en_s2[0] && s_r.sts3_s2;
  endproperty
  c_cov_sts3: cover property (p_cov_sts3);

  property p_cov_sts1;
    @(posedge link_clk) disable iff (!link_rst_n)
    rise_pin0 && seen_r && s_r.en_s2[0] && !s_r.sts3_s2;
  endproperty
  c_cov_sts1: cover property (p_cov_sts1);

  property p_cov_underrun;
    @(posedge link_clk) disable iff (!link_rst_n)
    s_r.en_s2[0] && rise[0] && !f_valid[0];
  endproperty
  c_cov_underrun: cover property (p_cov_underrun);

  property p_cov_pkt;
    @(posedge link_clk) disable iff (!link_rst_n)
    !s_r.en_s2[1] && s_r.alt_s2[1] == rx_tbus_pkg::ALT_PKT_SPACE && rx_bus_clock_out_ch1;
  endproperty
  c_cov_pkt: cover property (p_cov_pkt);

endmodule : rx_telecom_bus_clock_out

`default_nettype wire

// >>> hdl/rx_tbus_pkg.sv
`default_nettype none

package rx_tbus_pkg;

  // ==========================================================================
  // Channel count and word layout
  // ==========================================================================
  localparam int unsigned CHANNELS   = 3;
  localparam int unsigned FIFO_DEPTH = 16;
  localparam int unsigned WORD_W     = 11;
  localparam int unsigned BYTE_LSB   = 0;
  localparam int unsigned BYTE_W     = 8;
  localparam int unsigned ALARM_BIT  = 8;
  localparam int unsigned OVH_BIT    = 9;
  localparam int unsigned MARKER_BIT = 10;

  // ==========================================================================
  // Bus clock rates
  // ==========================================================================
  // The link clock is the reference from which both bus clock rates divide.
  localparam int unsigned REF_KHZ  = 155520;
  localparam int unsigned STS3_KHZ = 19440;
  localparam int unsigned STS1_KHZ = 6480;
  localparam int unsigned DIV_STS3 = REF_KHZ / STS3_KHZ;
  localparam int unsigned DIV_STS1 = REF_KHZ / STS1_KHZ;
  localparam int unsigned DIV_CNT_W = 5;
  localparam logic [DIV_CNT_W-1:0] DIV_STS3_C = DIV_CNT_W'(DIV_STS3);
  localparam logic [DIV_CNT_W-1:0] DIV_STS1_C = DIV_CNT_W'(DIV_STS1);

  // ==========================================================================
  // Alternate pin functions and idle values
  // ==========================================================================
  localparam logic [1:0] ALT_HDLC_GOOD = 2'h0;
  localparam logic [1:0] ALT_CELL_FLOW = 2'h1;
  localparam logic [1:0] ALT_PKT_SPACE = 2'h2;
  localparam int unsigned PKT_CHANNEL  = 1;

  localparam logic [7:0] IDLE_BYTE    = 8'h00;
  localparam logic       IDLE_ALARM   = 1'b1;
  localparam logic       IDLE_PAYLOAD = 1'b1;

endpackage : rx_tbus_pkg

`default_nettype wire

// >>> hdl/tbus_clock_divider.sv
`timescale 1ns/1ps
`default_nettype none

module tbus_clock_divider #(
  parameter int unsigned CNT_W = rx_tbus_pkg::DIV_CNT_W
) (
  // Link clock domain
  input  wire logic             clk,
  input  wire logic             rst_n,
  // Control
  input  wire logic             run,
  input  wire logic [CNT_W-1:0] div,
  // Generated bus clock
  output logic                  level,
  output logic                  level_nxt,
  output logic                  rise
);

  typedef struct packed {
    logic [CNT_W-1:0] cnt;
    logic             level;
  } div_state_t;

  div_state_t       s_r;
  div_state_t       s_nxt;
  logic [CNT_W-1:0] last;

  // ==========================================================================
  // Counter
  // ==========================================================================
  // The idle count is all ones so the first edge after run wraps to zero and
  // the bus clock rises at once; a rate change mid-period also wraps cleanly.
  always_comb begin
    last  = CNT_W'(div - 1'b1);
    s_nxt = s_r;
    if (!rst_n || !run) begin
      s_nxt.cnt   = '1;
      s_nxt.level = 1'b0;
    end else begin
      s_nxt.cnt   = (s_r.cnt >= last) ? '0 : CNT_W'(s_r.cnt + 1'b1);
      s_nxt.level = (s_nxt.cnt < (div >> 1));
    end
  end

  always_ff @(posedge clk) begin
    s_r <= s_nxt;
  end

  assign level     = s_r.level;
  assign level_nxt = s_nxt.level;
  assign rise      = s_nxt.level & ~s_r.level;

endmodule : tbus_clock_divider

`default_nettype wire

// >>> hdl/tbus_async_fifo.sv
`timescale 1ns/1ps
`default_nettype none

module tbus_async_fifo #(
  parameter int unsigned WIDTH = rx_tbus_pkg::WORD_W,
  parameter int unsigned DEPTH = rx_tbus_pkg::FIFO_DEPTH
) (
  // Write side
  input  wire logic             wclk,
  input  wire logic             wrst_n,
  input  wire logic             w_valid,
  input  wire logic [WIDTH-1:0] w_data,
  output logic                  w_ready,
  // Read side
  input  wire logic             rclk,
  input  wire logic             rrst_n,
  output logic                  r_valid,
  input  wire logic             r_ready,
  output logic [WIDTH-1:0]      r_data
);

  localparam int unsigned AW = $clog2(DEPTH);

  typedef logic [AW:0] ptr_t;
  typedef struct packed {
    ptr_t bin;
    ptr_t gray;
    ptr_t peer_s1;
    ptr_t peer_s2;
  } side_t;

  side_t            w_r;
  side_t            w_nxt;
  side_t            r_r;
  side_t            r_nxt;
  logic [WIDTH-1:0] mem [DEPTH];
  logic             push;
  logic             pop;

  function automatic ptr_t to_gray(input ptr_t b);
    return b ^ (b >> 1);
  endfunction : to_gray

  // ==========================================================================
  // Flags
  // ==========================================================================
  // Only gray pointers cross; DEPTH must be a power of two for this to hold.
  assign w_ready = wrst_n && (w_r.gray != {~w_r.peer_s2[AW:AW-1], w_r.peer_s2[AW-2:0]});
  assign r_valid = rrst_n && (r_r.gray != r_r.peer_s2);
  assign push    = w_valid && w_ready;
  assign pop     = r_valid && r_ready;
  assign r_data  = mem[r_r.bin[AW-1:0]];

  // ==========================================================================
  // Write domain
  // ==========================================================================
  always_comb begin
    w_nxt         = w_r;
    w_nxt.peer_s1 = r_r.gray;
    w_nxt.peer_s2 = w_r.peer_s1;
    if (push) begin
      w_nxt.bin  = ptr_t'(w_r.bin + 1'b1);
      w_nxt.gray = to_gray(w_nxt.bin);
    end
    if (!wrst_n) begin
      w_nxt = '0;
    end
  end

  always_ff @(posedge wclk) begin
    w_r <= w_nxt;
    if (push) begin
      mem[w_r.bin[AW-1:0]] <= w_data;
    end
  end

  // ==========================================================================
  // Read domain
  // ==========================================================================
  always_comb begin
    r_nxt         = r_r;
    r_nxt.peer_s1 = w_r.gray;
    r_nxt.peer_s2 = r_r.peer_s1;
    if (pop) begin
      r_nxt.bin  = ptr_t'(r_r.bin + 1'b1);
      r_nxt.gray = to_gray(r_nxt.bin);
    end
    if (!rrst_n) begin
      r_nxt = '0;
    end
  end

  always_ff @(posedge rclk) begin
    r_r <= r_nxt;
  end

  property p_wgray_one_step;
    @(posedge wclk) disable iff (!wrst_n)
    (w_r.gray != $past(w_r.gray)) |-> $onehot(w_r.gray ^ $past(w_r.gray));
  endproperty
  a_wgray_one_step: assert property (p_wgray_one_step) else $error("Write gray pointer moved by more than one bit.");

endmodule : tbus_async_fifo

`default_nettype wire

// >>> verif/tbus_sink.sv
`timescale 1ns/1ps
`default_nettype none

module tbus_sink (
  // Link clock
  input  wire logic            link_clk,
  // Receive bus pins of all three channels
  input  wire logic [2:0]      pin,
  input  wire logic [2:0][7:0] bus_byte,
  input  wire logic [2:0]      alarm,
  input  wire logic [2:0]      parity,
  input  wire logic [2:0]      payload,
  input  wire logic [2:0]      marker
);
  // ==========================================================================
  // Capture at each bus clock rise
  // ==========================================================================
  // Each entry is {marker, payload, parity, alarm, byte}.
  logic [11:0] q [3][$];
  int          period [3] = '{0, 0, 0};
  int          gap [3]    = '{0, 0, 0};
  logic [2:0]  pin_q      = 3'h0;

  // Sampling one link edge after the rise sees what that rise launched, as a receiver clocked by the pin would.
  always @(posedge link_clk) begin
    for (int c = 0; c < 3; c++) begin
      gap[c] = gap[c] + 1;
      if (pin[c] && !pin_q[c]) begin
        q[c].push_back({marker[c], payload[c], parity[c], alarm[c], bus_byte[c]});
        period[c] = gap[c];
        gap[c] = 0;
      end
    end
    pin_q <= pin;
  end
endmodule : tbus_sink

`default_nettype wire

// >>> verif/testbench.sv
`timescale 1ns/1ps
`default_nettype none

module testbench;
  // ==========================================================================
  // Clocks, stimulus and design
  // ==========================================================================
  logic            clk      = 1'b0;
  logic            link_clk = 1'b0;
  logic            reset_n;
  logic [2:0]      bus_enable;
  logic            sts3_mode;
  logic [2:0][1:0] alt_select;
  logic [2:0]      src_valid;
  logic [2:0]      src_ready;
  logic [2:0][7:0] src_byte;
  logic [2:0]      src_alarm;
  logic [2:0]      src_overhead;
  logic [2:0]      src_marker;
  logic [2:0]      hdlc_good;
  logic [2:0]      cell_flow;
  logic            pkt_space;
  wire [2:0]       pin;
  logic [2:0][7:0] bus_byte;
  logic [2:0]      bus_alarm;
  logic [2:0]      bus_parity;
  logic [2:0]      bus_payload;
  logic [2:0]      bus_marker;
  int              fail_count = 0;
  int              compares   = 0;
  int              cycles     = 0;

  always #2 clk = ~clk;

  // The odd start offset keeps link edges away from clk edges.
  initial begin
    #1.3;
    forever #3 link_clk = ~link_clk;
  end

  rx_telecom_bus_clock_out i_dut (
    .clk(clk), .reset_n(reset_n), .link_clk(link_clk),
    .bus_enable(bus_enable), .sts3_mode(sts3_mode), .alt_select(alt_select),
    .src_valid(src_valid), .src_ready(src_ready), .src_byte(src_byte),
    .src_alarm(src_alarm), .src_overhead(src_overhead), .src_frame_marker(src_marker),
    .rx_hdlc_good_check(hdlc_good), .rx_cell_flow_clock(cell_flow),
    .tx_pkt_selected_space_avail(pkt_space),
    .rx_bus_clock_out_ch0(pin[0]), .rx_bus_clock_out_ch1(pin[1]), .rx_bus_clock_out_ch2(pin[2]),
    .rx_bus_byte(bus_byte), .rx_bus_alarm(bus_alarm), .rx_bus_parity(bus_parity),
    .rx_bus_payload_flag(bus_payload), .rx_bus_frame_marker(bus_marker)
  );

  tbus_sink i_sink (
    .link_clk(link_clk), .pin(pin), .bus_byte(bus_byte), .alarm(bus_alarm),
    .parity(bus_parity), .payload(bus_payload), .marker(bus_marker)
  );

  // ==========================================================================
  // Reporting and comparison
  // ==========================================================================
  task automatic final_report;
    $display("Comparisons %0d, mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : final_report

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 6000) begin
      fail_count++;
      $display("ERROR %0t: run did not finish in time", $time);
      final_report();
    end
  end

  task automatic chk_word(logic [11:0] got, logic [11:0] exp);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk_word

  task automatic chk_num(int got, int exp);
    compares++;
    if (got != exp) begin
      fail_count++;
      $display("ERROR %0t: count %0d expected %0d", $time, got, exp);
    end
  endtask : chk_num

  // Bus view of a source word: payload is the inverse of overhead, parity makes the ones count odd.
  function automatic logic [11:0] bus_word(logic [7:0] b, logic a, logic o, logic m);
    return {m, ~o, ~^b, a, b};
  endfunction : bus_word

  // ==========================================================================
  // Scenarios
  // ==========================================================================
  // A disabled channel never drains, so valid held high must stop after exactly one FIFO depth.
  task automatic fill(int ch);
    int n;
    n = 0;
    @(posedge clk);
    for (int k = 0; k < 30; k++) begin
      src_valid[ch] <= 1'b1;
      src_byte[ch] <= 8'h30 + 8'(n);
      src_alarm[ch] <= n[1];
      src_overhead[ch] <= n[0];
      src_marker[ch] <= (n == 0);
      @(negedge clk);
      if (src_ready[ch] === 1'b1) n++;
      @(posedge clk);
    end
    src_valid[ch] <= 1'b0;
    chk_num(n, rx_tbus_pkg::FIFO_DEPTH);
  endtask : fill

  task automatic bus_rates;
    fill(0);
    fill(2);
    for (int c = 0; c < 3; c++) i_sink.q[c].delete();
    sts3_mode <= 1'b1;
    bus_enable <= 3'h5;
    for (int k = 0; k < 2000 && i_sink.q[0].size() < 18; k++) @(posedge clk);
    for (int c = 0; c < 3; c += 2) begin
      for (int i = 0; i < 16; i++) begin
        chk_word(i_sink.q[c].pop_front(), bus_word(8'h30 + 8'(i), i[1], i[0], i == 0));
      end
      chk_word(i_sink.q[c].pop_front(), bus_word(8'h00, 1'b1, 1'b0, 1'b0));
      chk_num(i_sink.period[c], 8);
    end
    chk_num(i_sink.q[1].size(), 0);
    chk_word({bus_marker[1], bus_payload[1], bus_parity[1], bus_alarm[1], bus_byte[1]}, 12'h000);
    sts3_mode <= 1'b0;
    repeat (200) @(posedge clk);
    chk_num(i_sink.period[0], 24);
    chk_num(i_sink.period[2], 24);
    bus_enable <= 3'h0;
    repeat (20) @(posedge clk);
  endtask : bus_rates

  task automatic alt_case(int ch, logic [1:0] sel, logic h, logic g, logic p, logic exp);
    @(posedge clk);
    alt_select[ch] <= sel;
    hdlc_good <= {3{h}};
    cell_flow <= {3{g}};
    pkt_space <= p;
    repeat (12) @(posedge clk);
    chk_word({11'h000, pin[ch]}, {11'h000, exp});
  endtask : alt_case

  initial begin
    reset_n = 1'b0;
    bus_enable = 3'h0;
    sts3_mode = 1'b1;
    alt_select = {3{2'h3}};
    src_valid = 3'h0;
    src_byte = '0;
    src_alarm = 3'h0;
    src_overhead = 3'h0;
    src_marker = 3'h0;
    hdlc_good = 3'h0;
    cell_flow = 3'h0;
    pkt_space = 1'b0;
    repeat (6) @(posedge clk);
    reset_n <= 1'b1;
    repeat (10) @(posedge clk);
    bus_rates();
    alt_case(0, 2'h0, 1'b1, 1'b0, 1'b0, 1'b1);
    alt_case(0, 2'h1, 1'b0, 1'b1, 1'b0, 1'b1);
    alt_case(1, 2'h2, 1'b0, 1'b0, 1'b1, 1'b1);
    alt_case(1, 2'h0, 1'b0, 1'b1, 1'b1, 1'b0);
    alt_case(2, 2'h2, 1'b1, 1'b1, 1'b1, 1'b0);
    alt_case(2, 2'h1, 1'b1, 1'b0, 1'b1, 1'b0);
    final_report();
  end
endmodule : testbench

`default_nettype wire
